// ==== rtl/phl_cfg.svh ====
/*
 * Constants of the peripheral handshake and latch control block:
 * register select codes, field positions, mode codes and reset values.
 * Assumes it is included by its bare name from the package and modules.
 */
`ifndef PHL_CFG_SVH
`define PHL_CFG_SVH

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define PHL_RS_W 4
`define PHL_OFS_OUT_B 4'h0
`define PHL_OFS_OUT_A 4'h1
`define PHL_OFS_AFC 4'hb
`define PHL_OFS_PLC 4'hc
`define PHL_OFS_FLG 4'hd
`define PHL_OFS_OUT_A_QUIET 4'hf

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PHL_FLG_A_AUX 0
`define PHL_FLG_A_EDGE 1
`define PHL_FLG_B_AUX 3
`define PHL_FLG_B_EDGE 4
`define PHL_PLC_A_SEL 0
`define PHL_PLC_A_MSB 3
`define PHL_PLC_A_LSB 1
`define PHL_PLC_B_SEL 4
`define PHL_PLC_B_MSB 7
`define PHL_PLC_B_LSB 5
`define PHL_AFC_A_LATCH 0
`define PHL_AFC_B_LATCH 1
`define PHL_AFC_SR_MSB 4
`define PHL_AFC_SR_LSB 2
`define PHL_MODE_OUT 2
`define PHL_MODE_POS 1
`define PHL_MODE_IND 0

// ----------------------------------------------------------------------
// Output mode codes (low two bits, top bit set) and reset values
// ----------------------------------------------------------------------
`define PHL_OM_HANDSHAKE 2'h0
`define PHL_OM_PULSE 2'h1
`define PHL_OM_LOW 2'h2
`define PHL_OM_HIGH 2'h3
`define PHL_SR_OFF 3'h0
`define PHL_PLC_RST 8'h00
`define PHL_AFC_RST 8'h00
`define PHL_AUX_IDLE 1'b1
`define PHL_BYTE_ZERO 8'h00

`endif

// ==== rtl/phl_ctrl.sv ====
/*
 * Peripheral handshake and latch control: four control lines, their
 * interrupt flags, the four auxiliary output modes and port input latching.
 * Assumes one register access per cycle on bus_i, port direction and
 * port B output register values supplied from outside, and that the
 * shift register drives the port B auxiliary line while it is enabled.
 */
// Functional notes
// RULE1 - Port A edge flag sets on fall when its select is 0, rise when 1
// RULE2 - Port A aux input mode: middle mode bit picks rising or falling edge
// RULE3 - Dependent port A aux input: any port A register access clears flag; the code does not clear it on the no-handshake alias
// RULE4 - Independent port A aux input: only writing 1 to its flag clears it
// RULE5 - Port A mode 100: low on port A access, high on edge input event
// RULE6 - Port A mode 101: low exactly one cycle after a port A access
// RULE7 - Port A mode 110 holds low, mode 111 holds high
// RULE8 - Port B edge flag follows select polarity, port B access clears it
// RULE9 - Port B edge flag still sets while the shift register uses the pin
// RULE10 - Port B aux mode field drives the line only with shifting disabled
// RULE11 - Port B aux input mode picks edge polarity with its middle bit
// RULE12 - Dependent port B aux input cleared by port B access, else untouched
// RULE13 - Port B mode 100: low on port B write, high on edge line event
// RULE14 - Port B mode 101: one-cycle low pulse after write only
// RULE15 - Port B mode 110 holds low, mode 111 holds high
// RULE16 - Enabled port A latch captures pins when edge flag sets, holds while set
// RULE17 - Aux control bit 0 enables port A latching, else latch is transparent
// RULE18 - Port A reads always return latch contents, even for output pins
// RULE19 - Aux control bit 1 gives port B the same latching and reads
// RULE20 - Port B latch takes pin for inputs, output register bit for outputs
// RULE21 - Flags sit at bits 0, 1, 3 and 4 of the flag register
// RULE22 - Flag register write clears set flags written 1; a new set wins
// RULE23 - Edges found by comparing each clocked sample with the previous one
// RULE24 - Reset clears both control registers
module phl_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input phl_pkg::phl_bus_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] port_a_pins_i,
    input wire logic [7:0] port_b_pins_i,
    input wire logic [7:0] port_b_output_register_i,
    input wire logic [7:0] port_b_dir_i,
    input phl_pkg::phl_lines_s lines_i,
    output logic port_a_aux_line_o,
    output logic port_a_aux_line_oe_o,
    output logic port_b_aux_line_o,
    output logic port_b_aux_line_oe_o,
    output logic [7:0] flags_o,
    output logic [7:0] peripheral_line_control_o,
    output logic [7:0] auxiliary_function_control_o
);
    import phl_pkg::*;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic wr, out_a_acc, out_b_acc, out_b_wr, flg_wr, sr_on;
    logic [7:0] clr_bits;
    logic [7:0] plc_q, plc_d, afc_q, afc_d;

    assign wr = bus_i.sel & ~bus_i.rd;
    // The no-handshake alias of port A is left out on purpose
    assign out_a_acc = bus_i.sel && (bus_i.rs == `PHL_OFS_OUT_A);
    assign out_b_acc = bus_i.sel && (bus_i.rs == `PHL_OFS_OUT_B);
    assign out_b_wr = out_b_acc & ~bus_i.rd;
    assign flg_wr = wr && (bus_i.rs == `PHL_OFS_FLG);
    assign clr_bits = flg_wr ? bus_i.wdata : `PHL_BYTE_ZERO;
    assign sr_on = afc_q[`PHL_AFC_SR_MSB:`PHL_AFC_SR_LSB] != `PHL_SR_OFF;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_comb begin
        plc_d = plc_q;
        afc_d = afc_q;
        if (wr && bus_i.rs == `PHL_OFS_PLC) begin
            plc_d = bus_i.wdata;
        end
        if (wr && bus_i.rs == `PHL_OFS_AFC) begin
            afc_d = bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            plc_q <= `PHL_PLC_RST; // see RULE24
            afc_q <= `PHL_AFC_RST; // see RULE24
        end else begin
            plc_q <= plc_d;
            afc_q <= afc_d;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection; index 0/1 edge lines A/B, 2/3 aux lines A/B
    // ------------------------------------------------------------------
    logic [3:0] rise, fall;

    phl_edge_det #(
        .N(4)
    ) u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i({lines_i.b_aux, lines_i.a_aux, lines_i.b_edge, lines_i.a_edge}),
        .rise_o(rise),
        .fall_o(fall)
    );

    // ------------------------------------------------------------------
    // Per-channel view, 0 = port A, 1 = port B
    // ------------------------------------------------------------------
    logic [2:0] mode [2];
    logic [1:0] sel, acc, trig, own, clr_edge, clr_aux;
    wire [1:0] edge_flag, aux_flag, aux_out, aux_oe;

    assign mode[0] = plc_q[`PHL_PLC_A_MSB:`PHL_PLC_A_LSB];
    assign mode[1] = plc_q[`PHL_PLC_B_MSB:`PHL_PLC_B_LSB];
    assign sel = {plc_q[`PHL_PLC_B_SEL], plc_q[`PHL_PLC_A_SEL]};
    assign acc = {out_b_acc, out_a_acc};
    // Port B handshakes start on writes only; port A on reads and writes
    assign trig = {out_b_wr, out_a_acc}; // see RULE13 see RULE14
    assign own = {~sr_on, 1'b1}; // see RULE10
    assign clr_edge = {clr_bits[`PHL_FLG_B_EDGE], clr_bits[`PHL_FLG_A_EDGE]};
    assign clr_aux = {clr_bits[`PHL_FLG_B_AUX], clr_bits[`PHL_FLG_A_AUX]};

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic edge_ev, aux_ev;
        logic ef_q, ef_d, af_q, af_d, ao_q, ao_d, oe_q, oe_d;

        // The edge pin flags even while it carries the shift clock
        assign edge_ev = sel[c] ? rise[c] : fall[c]; // see RULE1 see RULE8 see RULE9
        assign aux_ev = ~mode[c][`PHL_MODE_OUT]
            & (mode[c][`PHL_MODE_POS] ? rise[c+2] : fall[c+2]); // see RULE2 see RULE11

        always_comb begin
            // Set is ored in last, so a clear in the same cycle cannot lose it
            ef_d = edge_ev | (ef_q & ~(acc[c] | clr_edge[c])); // see RULE8 see RULE22
            af_d = aux_ev | (af_q & ~((acc[c] & ~mode[c][`PHL_MODE_IND])
                | clr_aux[c])); // see RULE3 see RULE4 see RULE12 see RULE22
            oe_d = mode[c][`PHL_MODE_OUT] & own[c]; // see RULE10
            ao_d = `PHL_AUX_IDLE;
            if (mode[c][`PHL_MODE_OUT]) begin
                unique case (mode[c][1:0])
                    `PHL_OM_HANDSHAKE: begin
                        // A new access beats a coincident edge: data is pending
                        if (trig[c]) begin
                            ao_d = 1'b0; // see RULE5 see RULE13
                        end else if (edge_ev) begin
                            ao_d = 1'b1; // see RULE5 see RULE13
                        end else begin
                            ao_d = ao_q;
                        end
                    end
                    `PHL_OM_PULSE: ao_d = ~trig[c]; // see RULE6 see RULE14
                    `PHL_OM_LOW: ao_d = 1'b0; // see RULE7 see RULE15
                    `PHL_OM_HIGH: ao_d = 1'b1; // see RULE7 see RULE15
                endcase
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ef_q <= 1'b0;
                af_q <= 1'b0;
                ao_q <= `PHL_AUX_IDLE;
                oe_q <= 1'b0;
            end else begin
                ef_q <= ef_d;
                af_q <= af_d;
                ao_q <= ao_d;
                oe_q <= oe_d;
            end
        end

        assign edge_flag[c] = ef_q;
        assign aux_flag[c] = af_q;
        assign aux_out[c] = ao_q;
        assign aux_oe[c] = oe_q;
    end

    // ------------------------------------------------------------------
    // Input latches
    // ------------------------------------------------------------------
    logic [7:0] a_latch, b_latch, b_src;

    // Output pins report what the output register drives, not the wire
    assign b_src = (port_b_dir_i & port_b_output_register_i)
        | (~port_b_dir_i & port_b_pins_i); // see RULE20

    phl_in_latch #(
        .W(8)
    ) u_latch_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(afc_q[`PHL_AFC_A_LATCH]), // see RULE17
        .hold_i(edge_flag[0]),
        .data_i(port_a_pins_i),
        .latch_o(a_latch)
    );

    phl_in_latch #(
        .W(8)
    ) u_latch_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(afc_q[`PHL_AFC_B_LATCH]), // see RULE19
        .hold_i(edge_flag[1]),
        .data_i(b_src),
        .latch_o(b_latch)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d, flags;

    always_comb begin
        flags = `PHL_BYTE_ZERO;
        flags[`PHL_FLG_A_AUX] = aux_flag[0]; // see RULE21
        flags[`PHL_FLG_A_EDGE] = edge_flag[0]; // see RULE21
        flags[`PHL_FLG_B_AUX] = aux_flag[1]; // see RULE21
        flags[`PHL_FLG_B_EDGE] = edge_flag[1]; // see RULE21
    end

    always_comb begin
        rdata_d = `PHL_BYTE_ZERO;
        if (bus_i.sel && bus_i.rd) begin
            unique case (bus_i.rs)
                `PHL_OFS_OUT_A, `PHL_OFS_OUT_A_QUIET: rdata_d = a_latch; // see RULE18
                `PHL_OFS_OUT_B: rdata_d = b_latch; // see RULE19
                `PHL_OFS_PLC: rdata_d = plc_q;
                `PHL_OFS_AFC: rdata_d = afc_q;
                `PHL_OFS_FLG: rdata_d = flags;
                default: rdata_d = `PHL_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= `PHL_BYTE_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign flags_o = flags;
    assign port_a_aux_line_o = aux_out[0];
    assign port_a_aux_line_oe_o = aux_oe[0];
    assign port_b_aux_line_o = aux_out[1];
    assign port_b_aux_line_oe_o = aux_oe[1];
    assign peripheral_line_control_o = plc_q;
    assign auxiliary_function_control_o = afc_q;

endmodule // phl_ctrl

// ==== rtl/phl_edge_det.sv ====
/*
 * Sampled edge detector for N control lines.
 * Assumes inputs are already synchronous to clk_i.
 */
module phl_edge_det #(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] line_i,
    output logic [N-1:0] rise_o,
    output logic [N-1:0] fall_o
);

    logic [N-1:0] smp_q, smp_d, prev_q, prev_d;

    // ------------------------------------------------------------------
    // Sample and previous sample
    // ------------------------------------------------------------------
    always_comb begin
        smp_d = line_i;
        prev_d = smp_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset both to idle high so a high line at release reads as no edge; a low one reads as a fall
            smp_q <= '1;
            prev_q <= '1;
        end else begin
            smp_q <= smp_d;
            prev_q <= prev_d;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_line
        assign rise_o[i] = smp_q[i] & ~prev_q[i]; // see RULE23
        assign fall_o[i] = ~smp_q[i] & prev_q[i]; // see RULE23
    end

endmodule // phl_edge_det

// ==== rtl/phl_in_latch.sv ====
/*
 * Input latch for one port: transparent while disabled or not holding,
 * frozen while enabled and holding.
 * Assumes hold_i is the port's edge flag register.
 */
module phl_in_latch #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic hold_i,
    input wire logic [W-1:0] data_i,
    output logic [W-1:0] latch_o
);

    logic [W-1:0] latch_q, latch_d;

    always_comb begin
        // While the flag is clear the latch follows, so it holds the value of
        // the very cycle in which the flag sets
        latch_d = (en_i && hold_i) ? latch_q : data_i; // see RULE16
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= '0;
        end else begin
            latch_q <= latch_d;
        end
    end

    assign latch_o = latch_q;

endmodule // phl_in_latch

// ==== rtl/phl_pkg.sv ====
/*
 * Types shared by the peripheral handshake and latch control block.
 * Assumes phl_cfg.svh is on the include path.
 */
`include "phl_cfg.svh"

package phl_pkg;

    // One register access per cycle while sel is high
    typedef struct packed {
        logic sel;
        logic rd;
        logic [`PHL_RS_W-1:0] rs;
        logic [7:0] wdata;
    } phl_bus_s;

    // The four control lines as seen at the pins
    typedef struct packed {
        logic b_aux;
        logic a_aux;
        logic b_edge;
        logic a_edge;
    } phl_lines_s;

endpackage

// ==== tb/phl_ctrl_assertions.sv ====
/*
 * Port checker for phl_ctrl: flag setting, flag layout and aux line modes.
 * Assumes it is bound to phl_ctrl and sees only that module's ports.
 */
`include "phl_cfg.svh"
module phl_ctrl_assertions
    import phl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input phl_pkg::phl_bus_s bus_i,
    input phl_pkg::phl_lines_s lines_i,
    input wire logic port_a_aux_line_o,
    input wire logic port_a_aux_line_oe_o,
    input wire logic port_b_aux_line_o,
    input wire logic port_b_aux_line_oe_o,
    input wire logic [7:0] flags_o,
    input wire logic [7:0] peripheral_line_control_o,
    input wire logic [7:0] auxiliary_function_control_o
);
    logic [7:0] plc;
    logic out_a_acc, out_b_acc, sr_off;
    assign plc = peripheral_line_control_o;
    assign out_a_acc = bus_i.sel && bus_i.rs == `PHL_OFS_OUT_A;
    assign out_b_acc = bus_i.sel && bus_i.rs == `PHL_OFS_OUT_B;
    assign sr_off = auxiliary_function_control_o[4:2] == 3'h0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_flag_layout: assert property (flags_o[7:5] == 3'h0 && !flags_o[2])
        else $error("Flag outside its fixed position");
    chk_a_edge_set: assert property ($fell(lines_i.a_edge) && !plc[0]
        && $stable(plc) |-> ##2 flags_o[1]) else $error("Port A edge flag missed");
    chk_b_edge_set: assert property ($rose(lines_i.b_edge) && plc[4]
        && $stable(plc) |-> ##2 flags_o[4]) else $error("Port B edge flag missed");
    chk_a_indep_keep: assert property (out_a_acc && !plc[3] && plc[1] && flags_o[0]
        |=> flags_o[0]) else $error("Independent aux flag cleared by port access");
    chk_a_handshake: assert property (out_a_acc && plc[3:1] == 3'h4
        |=> !port_a_aux_line_o && port_a_aux_line_oe_o) else $error("Handshake not low");
    chk_a_pulse: assert property (out_a_acc && plc[3:1] == 3'h5 ##1 !bus_i.sel
        |-> !port_a_aux_line_o ##1 port_a_aux_line_o) else $error("Port A pulse wrong");
    chk_a_manual_low: assert property (plc[3:1] == 3'h6 ##1 plc[3:1] == 3'h6
        |-> !port_a_aux_line_o && port_a_aux_line_oe_o) else $error("Port A not held low");
    chk_a_input_oe: assert property (!plc[3] ##1 !plc[3]
        |-> !port_a_aux_line_oe_o) else $error("Port A aux driven in input mode");
    chk_b_shift_owns: assert property (!sr_off ##1 !sr_off
        |-> !port_b_aux_line_oe_o) else $error("Port B aux driven while shifting");
    chk_b_read_quiet: assert property (out_b_acc && bus_i.rd && plc[7:5] == 3'h5
        && sr_off && port_b_aux_line_o |=> port_b_aux_line_o) else $error("Read pulsed B");
    chk_b_handshake: assert property (out_b_acc && !bus_i.rd && plc[7:5] == 3'h4
        && sr_off |=> !port_b_aux_line_o) else $error("Port B handshake not low");

    cov_a_handshake: cover property (out_a_acc && plc[3:1] == 3'h4);
    cov_b_pulse: cover property (out_b_acc && !bus_i.rd && plc[7:5] == 3'h5);
    cov_b_edge_shift: cover property (flags_o[4] && !sr_off);
endmodule // phl_ctrl_assertions

bind phl_ctrl phl_ctrl_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
    .lines_i(lines_i), .port_a_aux_line_o(port_a_aux_line_o),
    .port_a_aux_line_oe_o(port_a_aux_line_oe_o), .port_b_aux_line_o(port_b_aux_line_o),
    .port_b_aux_line_oe_o(port_b_aux_line_oe_o), .flags_o(flags_o),
    .peripheral_line_control_o(peripheral_line_control_o),
    .auxiliary_function_control_o(auxiliary_function_control_o));

// ==== tb/phl_periph_model.sv ====
/*
 * Peripheral device model on the four control lines.
 * Assumes the bench commands static levels; handshakes are answered here.
 */
module phl_periph_model
    import phl_pkg::*;
(
    input wire logic clk_i,
    input wire logic [3:0] lvl_i,
    input wire logic ack_en_i,
    input wire logic aux_a_i,
    input wire logic aux_a_oe_i,
    input wire logic aux_b_i,
    input wire logic aux_b_oe_i,
    output phl_pkg::phl_lines_s lines_o
);
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    // Answers a lowered handshake at the next falling edge, half a cycle late
    always @(negedge clk_i) begin
        ack_a <= ack_en_i && aux_a_oe_i && !aux_a_i;
        ack_b <= ack_en_i && aux_b_oe_i && !aux_b_i;
    end
    // Aux wires: device level while it drives, else this model's level
    assign lines_o = {aux_b_oe_i ? aux_b_i : lvl_i[3], aux_a_oe_i ? aux_a_i : lvl_i[2],
                      lvl_i[1] ^ ack_b, lvl_i[0] ^ ack_a};
endmodule // phl_periph_model

// ==== tb/test_peripheral_handshake_latch_control.sv ====
/*
 * Self-checking bench for phl_ctrl with a peripheral model on the lines.
 * Assumes inputs change on the falling edge; the bench drives the pins.
 */
`include "phl_cfg.svh"
module test_peripheral_handshake_latch_control
    import phl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [3:0] rs; logic [7:0] wd, rd; logic [1:0] aux;} phl_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    phl_bus_s bus = '0;
    logic [7:0] pins_a = 8'h00, pins_b = 8'h00, out_b = 8'h00, dir = 8'h00;
    logic [7:0] rdata, flags, plc, afc;
    logic [3:0] lvl = 4'hf;
    logic ack_en = 1'b0;
    logic aa, aa_oe, ba, ba_oe;
    phl_lines_s lines;
    int failures = 0;
    int n_compared = 0;
    phl_row_s rows [5] = '{'{`PHL_OFS_PLC, 8'hee, 8'hee, 2'h3},
        '{`PHL_OFS_PLC, 8'hcc, 8'hcc, 2'h0}, '{`PHL_OFS_AFC, 8'h03, 8'h03, 2'h0},
        '{4'h2, 8'h5a, 8'h00, 2'h0}, '{`PHL_OFS_AFC, 8'h00, 8'h00, 2'h0}};

    always #25 clk = ~clk;

    phl_ctrl i_dut (.clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata),
        .port_a_pins_i(pins_a), .port_b_pins_i(pins_b), .port_b_output_register_i(out_b),
        .port_b_dir_i(dir), .lines_i(lines), .port_a_aux_line_o(aa),
        .port_a_aux_line_oe_o(aa_oe), .port_b_aux_line_o(ba), .port_b_aux_line_oe_o(ba_oe),
        .flags_o(flags), .peripheral_line_control_o(plc), .auxiliary_function_control_o(afc));
    phl_periph_model i_model (.clk_i(clk), .lvl_i(lvl), .ack_en_i(ack_en), .aux_a_i(aa),
        .aux_a_oe_i(aa_oe), .aux_b_i(ba), .aux_b_oe_i(ba_oe), .lines_o(lines));

    // --------
    // Tasks
    // --------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One register access; read data is settled when this returns
    task automatic acc(input logic rd, input logic [3:0] rs, input logic [7:0] wd);
        @(negedge clk);
        bus = '{sel: 1'b1, rd: rd, rs: rs, wdata: wd};
        @(negedge clk);
        bus.sel = 1'b0;
    endtask

    // New line levels, then wait until a resulting flag is visible
    task automatic lv(input logic [3:0] v);
        @(negedge clk);
        lvl = v;
        repeat (2) @(negedge clk);
    endtask

    task automatic end_sim;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk({flags[4:0], aa, ba, aa_oe | ba_oe}, 8'h06);
        chk(plc | afc, 8'h00);
        foreach (rows[i]) begin
            acc(1'b0, rows[i].rs, rows[i].wd);
            acc(1'b1, rows[i].rs, 8'h00);
            chk(rdata, rows[i].rd);
            chk({aa, ba}, rows[i].aux);
        end
        acc(1'b0, `PHL_OFS_PLC, 8'h10);
        lv(4'b1110);
        chk(flags, 8'h02);
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk(flags, 8'h00);
        acc(1'b0, `PHL_OFS_AFC, 8'h1c);
        lv(4'b1100);
        chk(flags, 8'h00);
        lv(4'b1110);
        chk(flags, 8'h10);
        chk(ba_oe, 1'b0);
        acc(1'b0, `PHL_OFS_OUT_B, 8'h00);
        chk(flags, 8'h00);
        acc(1'b0, `PHL_OFS_AFC, 8'h00);
        lv(4'hf);
        acc(1'b0, `PHL_OFS_PLC, 8'h00);
        lv(4'b1011);
        chk(flags, 8'h01);
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk(flags, 8'h00);
        acc(1'b0, `PHL_OFS_PLC, 8'h66);
        lv(4'hf);
        chk(flags, 8'h01);
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk(flags, 8'h01);
        acc(1'b0, `PHL_OFS_FLG, 8'h1e);
        chk(flags, 8'h01);
        acc(1'b0, `PHL_OFS_FLG, 8'h01);
        chk(flags, 8'h00);
        acc(1'b0, `PHL_OFS_PLC, 8'h44);
        lv(4'b0111);
        chk(flags, 8'h00);
        lv(4'hf);
        chk(flags, 8'h08);
        acc(1'b0, `PHL_OFS_OUT_B, 8'h00);
        chk(flags, 8'h00);
        // Handshake: the model answers each lowered line with an edge
        acc(1'b0, `PHL_OFS_PLC, 8'h88);
        acc(1'b1, `PHL_OFS_OUT_B, 8'h00);
        chk(ba, 1'b1);
        chk({aa_oe, ba_oe}, 2'h3);
        ack_en = 1'b1;
        acc(1'b0, `PHL_OFS_OUT_A, 8'h00);
        chk(aa, 1'b0);
        for (int i = 0; i < 8 && aa !== 1'b1; i++) @(negedge clk);
        chk(aa, 1'b1);
        acc(1'b0, `PHL_OFS_OUT_B, 8'h00);
        chk(ba, 1'b0);
        for (int i = 0; i < 8 && ba !== 1'b1; i++) @(negedge clk);
        chk(ba, 1'b1);
        ack_en = 1'b0;
        repeat (2) @(negedge clk);
        chk(flags, 8'h12);
        acc(1'b0, `PHL_OFS_FLG, 8'h12);
        chk(flags, 8'h00);
        acc(1'b0, `PHL_OFS_PLC, 8'haa);
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk({aa, ba}, 2'h1);
        @(negedge clk);
        chk({aa, ba}, 2'h3);
        acc(1'b1, `PHL_OFS_OUT_B, 8'h00);
        chk({aa, ba}, 2'h3);
        acc(1'b0, `PHL_OFS_OUT_B, 8'h00);
        chk({aa, ba}, 2'h2);
        @(negedge clk);
        chk({aa, ba}, 2'h3);
        // Latching: pins move after capture, reads must not follow
        acc(1'b0, `PHL_OFS_PLC, 8'h00);
        acc(1'b0, `PHL_OFS_AFC, 8'h03);
        pins_a = 8'h5a;
        pins_b = 8'h96;
        dir = 8'h0f;
        out_b = 8'h33;
        lv(4'b1100);
        pins_a = 8'ha5;
        pins_b = 8'h69;
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk(rdata, 8'h5a);
        acc(1'b1, `PHL_OFS_OUT_B, 8'h00);
        chk(rdata, 8'h93);
        acc(1'b0, `PHL_OFS_AFC, 8'h00);
        acc(1'b1, `PHL_OFS_OUT_A, 8'h00);
        chk(rdata, 8'ha5);
        acc(1'b1, `PHL_OFS_OUT_B, 8'h00);
        chk(rdata, 8'h63);
        end_sim();
    end

    // Whole run needs well under 400 cycles
    initial begin
        #(4000 * 50);
        failures++;
        end_sim();
    end
endmodule // test_peripheral_handshake_latch_control
